// file: host_ctrl_model.sv
// serial bus controller model: start, stop and byte moves on the port
// assumes the bench resolves the open-drain data wire with a pull-up
`timescale 1ns/1ps
module host_ctrl_model (
  input  wire logic clk,
  input  wire logic sda_w,
  input  wire logic hs,
  output logic      scl,
  output logic      sda_h
);
  initial
  begin
    scl = 1'b1;
    sda_h = 1'b1;
  end

  // one bus phase, sized to the selected speed
  task automatic hold();
    repeat (hs ? 8 : 63) @(posedge clk);
  endtask : hold

  task automatic bit_out(input logic b);
    sda_h <= b;
    hold();
    scl <= 1'b1;
    hold();
    scl <= 1'b0;
    hold();
  endtask : bit_out

  task automatic start();
    sda_h <= 1'b1;
    hold();
    scl <= 1'b1;
    hold();
    sda_h <= 1'b0;
    hold();
    scl <= 1'b0;
    hold();
  endtask : start

  task automatic stop();
    sda_h <= 1'b0;
    hold();
    scl <= 1'b1;
    hold();
    sda_h <= 1'b1;
    hold();
  endtask : stop

  task automatic wbyte(input logic [7:0] b, output logic a);
    for (int i = 7; i >= 0; i--)
      bit_out(b[i]);
    sda_h <= 1'b1;
    hold();
    scl <= 1'b1;
    hold();
    a = !sda_w;
    scl <= 1'b0;
    hold();
  endtask : wbyte

  task automatic rbyte(output logic [7:0] b, input logic ack);
    sda_h <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      hold();
      scl <= 1'b1;
      hold();
      b = {b[6:0], sda_w};
      scl <= 1'b0;
    end
    bit_out(!ack);
  endtask : rbyte
endmodule : host_ctrl_model

// file: host_port_cfg.sv
// host-facing serial target with pin, pad, queue and sample-spacing control
// assumes scl and sda arrive from pins; queue is filled by on-chip logic
`timescale 1ns/1ps
module host_port_cfg
  import host_port_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2A,
  parameter int         QAW      = 4
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  input  wire logic        irq_pin_in,
  input  wire logic        open_drain_select,
  input  wire logic        adc_run,
  input  wire logic        push_valid,
  input  wire logic [15:0] push_data,
  output logic             push_ready_q,
  output logic             sda_out_q,
  output logic             sda_oe_n_q,
  output logic             slew_limit_en_q,
  output logic             hs_mode_q,
  output logic             adc_sample_q,
  output irq_pin_t         irq_pin_q
);
  `include "host_port_consts.svh"

  // ---------------------------------------------------------------
  // pin synchronisers and bus conditions
  // ---------------------------------------------------------------
  logic scl_s1, scl_s2, scl_p, sda_s1, sda_s2, sda_p, pin_s1, pin_s2, od_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      {scl_s1, scl_s2, scl_p} <= 3'h7;
      {sda_s1, sda_s2, sda_p} <= 3'h7;
      {pin_s1, pin_s2, od_q}  <= 3'h0;
    end
    else
    begin
      {scl_s1, scl_s2, scl_p} <= {scl_in, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_p} <= {sda_in, sda_s1, sda_s2};
      {pin_s1, pin_s2, od_q}  <= {irq_pin_in, pin_s1, open_drain_select};
    end
  end

  wire scl_rise  = scl_s2 & ~scl_p;
  wire scl_fall  = ~scl_s2 & scl_p;
  wire bus_start = scl_s2 & scl_p & sda_p & ~sda_s2;
  wire bus_stop  = scl_s2 & scl_p & ~sda_p & sda_s2;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [15:0] adc_q, pad_q, pol_q, ctrl_q, th_q;
  logic [4:0]  status_q;
  reg_write_t  wr_q;
  logic        nack_used_q;

  wire wr_adc  = wr_q.valid && wr_q.addr == `OFS_ADC_POST;
  wire wr_pad  = wr_q.valid && wr_q.addr == `OFS_PIN_PAD;
  wire wr_pol  = wr_q.valid && wr_q.addr == `OFS_PIN_POL;
  wire wr_ctrl = wr_q.valid && wr_q.addr == `OFS_SERIAL_CTRL;
  wire wr_th   = wr_q.valid && wr_q.addr == `OFS_QUEUE_TH;
  wire wr_stat = wr_q.valid && wr_q.addr == `OFS_IRQ_STATUS;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      adc_q  <= `RST_ADC_POST;
      pad_q  <= `RST_PIN_PAD;
      pol_q  <= `RST_PIN_POL;
      ctrl_q <= `RST_SERIAL_CTRL;
      th_q   <= `RST_QUEUE_TH;
    end
    else
    begin
      if (wr_adc) adc_q <= wr_q.data;
      if (wr_pad) pad_q <= wr_q.data;
      if (wr_pol) pol_q <= wr_q.data;
      if (wr_th)  th_q  <= wr_q.data;
      if (wr_ctrl) ctrl_q <= wr_q.data;
      else if (nack_used_q) ctrl_q[`BIT_NACK] <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // data queue
  // ---------------------------------------------------------------
  logic [QAW-1:0] qwr_q, qrd_q;
  logic [QAW:0]   qcnt_q;
  logic [15:0]    qdata;
  logic           pop;

  wire q_full  = qcnt_q == (QAW+1)'(1 << QAW);
  wire q_empty = qcnt_q == '0;
  wire q_push  = push_valid & push_ready_q;
  wire q_pop   = pop & ~q_empty;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      qwr_q <= '0;
      qrd_q <= '0;
      qcnt_q <= '0;
      push_ready_q <= 1'b0;
    end
    else
    begin
      if (q_push) qwr_q <= qwr_q + 1'b1;
      if (q_pop)  qrd_q <= qrd_q + 1'b1;
      qcnt_q <= qcnt_q + (QAW+1)'(q_push) - (QAW+1)'(q_pop);
      push_ready_q <= (qcnt_q + (QAW+1)'(q_push)) < (QAW+1)'(1 << QAW) || q_pop;
    end
  end

  queue_mem #(.WIDTH(16), .AW(QAW)) u_mem (
    .clk     (clk),
    .we      (q_push),
    .waddr   (qwr_q),
    .wdata   (push_data),
    .raddr   (q_pop ? qrd_q + 1'b1 : qrd_q),
    .rdata_q (qdata)
  );

  // ---------------------------------------------------------------
  // serial target
  // ---------------------------------------------------------------
  port_state_t st_q, after_q;
  logic [7:0]  sh_q, ptr_q, first_q;
  logic [3:0]  bit_q;
  logic        half_q, hack_q, addressed_q;
  logic [1:0]  reload_q;
  logic        ev_addr, ev_rstart, ev_stop;

  wire [15:0] rd_word = ptr_q == `OFS_QUEUE_DATA  ? qdata :
                        ptr_q == `OFS_ADC_POST    ? adc_q :
                        ptr_q == `OFS_PIN_PAD     ? pad_q :
                        ptr_q == `OFS_PIN_POL     ? pol_q :
                        ptr_q == `OFS_SERIAL_CTRL ? ctrl_q :
                        ptr_q == `OFS_QUEUE_TH    ? th_q :
                        ptr_q == `OFS_IRQ_STATUS  ? {11'h000, status_q} : 16'h0000;
  wire        sel_hi  = ctrl_q[`BIT_HI_FIRST] ^ half_q;
  wire [7:0]  tx_byte = sel_hi ? rd_word[15:8] : rd_word[7:0];
  wire        lo_wr   = ctrl_q[`BIT_LO_WR_FIRST];
  wire [15:0] wr_word = lo_wr ? {sh_q, first_q} : {first_q, sh_q};
  wire        hit     = sh_q[7:1] == DEV_ADDR;
  wire        reading = st_q == S_RD || st_q == S_MACK || (st_q == S_ACK && after_q == S_RD);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_q <= S_IDLE;
      after_q <= S_IDLE;
      {sh_q, ptr_q, first_q} <= '0;
      {bit_q, reload_q} <= '0;
      {half_q, hack_q, addressed_q, nack_used_q} <= '0;
      {ev_addr, ev_rstart, ev_stop, pop} <= '0;
      sda_oe_n_q <= 1'b1;
      wr_q <= '0;
    end
    else
    begin
      {ev_addr, ev_rstart, ev_stop, pop, nack_used_q} <= '0;
      wr_q.valid <= 1'b0;
      if (reload_q != 2'd0) reload_q <= reload_q - 2'd1;
      if (reload_q == 2'd1 && st_q == S_RD) sda_oe_n_q <= tx_byte[7];
      if (bus_stop)
      begin
        st_q <= S_IDLE;
        ev_stop <= 1'b1;
        addressed_q <= 1'b0;
        sda_oe_n_q <= 1'b1;
      end
      else if (bus_start)
      begin
        ev_rstart <= addressed_q;
        st_q <= S_ADDR;
        bit_q <= '0;
        sda_oe_n_q <= 1'b1;
      end
      else if (scl_rise)
      begin
        if (st_q == S_ADDR || st_q == S_REG || st_q == S_WR)
        begin
          sh_q <= {sh_q[6:0], sda_s2};
          bit_q <= bit_q + 1'b1;
        end
        if (st_q == S_MACK) hack_q <= ~sda_s2;
      end
      else if (scl_fall)
      begin
        case (st_q)
          S_ADDR, S_REG, S_WR:
          begin
            if (bit_q == 4'd8)
            begin
              bit_q <= '0;
              st_q <= S_ACK;
              sda_oe_n_q <= 1'b0;
              if (st_q == S_ADDR)
              begin
                after_q <= sh_q[0] ? S_RD : S_REG;
                half_q <= 1'b0;
                if (!hit || ctrl_q[`BIT_NACK])
                begin
                  st_q <= S_IDLE;
                  sda_oe_n_q <= 1'b1;
                  nack_used_q <= hit;
                end
                else
                begin
                  ev_addr <= 1'b1;
                  addressed_q <= 1'b1;
                end
              end
              else if (st_q == S_REG)
              begin
                ptr_q <= sh_q;
                after_q <= S_WR;
              end
              else
              begin
                first_q <= sh_q;
                half_q <= ~half_q;
                wr_q.valid <= half_q;
                wr_q.addr <= ptr_q;
                wr_q.data <= wr_word;
              end
            end
          end
          S_ACK:
          begin
            st_q <= after_q;
            sda_oe_n_q <= 1'b1;
            if (after_q == S_RD)
            begin
              sda_oe_n_q <= tx_byte[7];
              bit_q <= 4'd1;
            end
          end
          S_RD:
          begin
            sda_oe_n_q <= tx_byte[3'd7 - bit_q[2:0]];
            bit_q <= bit_q + 1'b1;
            if (bit_q == 4'd8)
            begin
              st_q <= S_MACK;
              bit_q <= '0;
              sda_oe_n_q <= 1'b1;
            end
          end
          S_MACK:
          begin
            st_q <= hack_q ? S_RD : S_IDLE;
            if (hack_q)
            begin
              bit_q <= 4'd1;
              reload_q <= 2'd3;
              half_q <= ~half_q;
              pop <= half_q && ptr_q == `OFS_QUEUE_DATA;
            end
          end
          default: st_q <= S_IDLE;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt sources and pin
  // ---------------------------------------------------------------
  wire [3:0] th_words = th_q[`TH_MSB:`TH_LSB];
  wire [4:0] set_vec;
  assign set_vec[`ST_ADDR_HIT] = ev_addr & ctrl_q[`BIT_IRQ_ADDR];
  assign set_vec[`ST_RSTART]   = ev_rstart & ctrl_q[`BIT_IRQ_RSTART];
  assign set_vec[`ST_STOP]     = ev_stop & ctrl_q[`BIT_IRQ_STOP];
  assign set_vec[`ST_TXREQ]    = reading & ~q_full & ctrl_q[`BIT_IRQ_TXREQ];
  assign set_vec[`ST_QUEUE]    = th_words != 4'h0 && qcnt_q >= (QAW+1)'(th_words);
  wire [4:0] clr_vec = wr_stat ? wr_q.data[4:0] : 5'h00;

  wire pending  = |status_q;
  wire pin_lvl  = pending ^ pol_q[`BIT_PIN_POL];
  wire pmos_on  = pad_q[`BIT_PIN_OE] & ~pad_q[`BIT_PULLUP_DIS] & ~od_q;
  wire nmos_on  = pad_q[`BIT_PIN_OE] & ~pin_lvl;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      status_q <= '0;
      irq_pin_q <= '{level: 1'b0, oe_n: 1'b1, pullup_on: 1'b0, sensed: 1'b0};
      {slew_limit_en_q, hs_mode_q, adc_sample_q, sda_out_q} <= 4'h8;
    end
    else
    begin
      status_q <= (status_q & ~clr_vec) | set_vec;
      irq_pin_q.level     <= pin_lvl;
      irq_pin_q.oe_n      <= ~(nmos_on | (pmos_on & pin_lvl));
      irq_pin_q.pullup_on <= pmos_on & pin_lvl;
      irq_pin_q.sensed    <= pad_q[`BIT_PIN_IE] & pin_s2;
      slew_limit_en_q     <= pad_q[`BIT_SLOPE_EN];
      hs_mode_q           <= ctrl_q[`BIT_SPEED_HS];
      adc_sample_q <= adc_run & ~(adc_q[`BIT_ADC_SPACING] & adc_sample_q);
      sda_out_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_spacing;
    @(posedge clk) disable iff (rst)
    adc_q[`BIT_ADC_SPACING] && adc_sample_q |=> !adc_sample_q;
  endproperty
  a_spacing: assert property (p_spacing) else $error("sample spacing lost");
  property p_no_drive;
    @(posedge clk) disable iff (rst)
    !pad_q[`BIT_PIN_OE] |=> irq_pin_q.oe_n && !irq_pin_q.pullup_on;
  endproperty
  a_no_drive: assert property (p_no_drive) else $error("pin driven while disabled");
  property p_pullup_off;
    @(posedge clk) disable iff (rst)
    pad_q[`BIT_PULLUP_DIS] |=> !irq_pin_q.pullup_on;
  endproperty
  a_pullup_off: assert property (p_pullup_off) else $error("pull-up on while disabled");
  property p_polarity;
    @(posedge clk) disable iff (rst)
    1'b1 |=> irq_pin_q.level == ($past(|status_q) ^ $past(pol_q[`BIT_PIN_POL]));
  endproperty
  a_polarity: assert property (p_polarity) else $error("pin level wrong");
  property p_sense;
    @(posedge clk) disable iff (rst)
    !pad_q[`BIT_PIN_IE] |=> !irq_pin_q.sensed;
  endproperty
  a_sense: assert property (p_sense) else $error("pin sensed while input off");
  property p_slew;
    @(posedge clk) disable iff (rst)
    1'b1 |=> slew_limit_en_q == $past(pad_q[`BIT_SLOPE_EN]);
  endproperty
  a_slew: assert property (p_slew) else $error("slew enable mismatch");
  property p_stop_irq;
    @(posedge clk) disable iff (rst)
    bus_stop && ctrl_q[`BIT_IRQ_STOP] |-> ##2 status_q[`ST_STOP];
  endproperty
  a_stop_irq: assert property (p_stop_irq) else $error("stop not flagged");
  property p_nack_once;
    @(posedge clk) disable iff (rst)
    nack_used_q && !wr_ctrl |=> !ctrl_q[`BIT_NACK];
  endproperty
  a_nack_once: assert property (p_nack_once) else $error("nack not consumed");
  property p_threshold;
    @(posedge clk) disable iff (rst)
    th_words != 4'h0 && qcnt_q >= (QAW+1)'(th_words) |=> status_q[`ST_QUEUE];
  endproperty
  a_threshold: assert property (p_threshold) else $error("queue level not flagged");
  property p_pin_idle;
    @(posedge clk) disable iff (rst)
    status_q == 5'h00 && pol_q[`BIT_PIN_POL] ##1 1'b1 |-> irq_pin_q.level;
  endproperty
  a_pin_idle: assert property (p_pin_idle) else $error("pin active with none pending");
endmodule : host_port_cfg

// file: host_port_cfg_tb_top.sv
// self-checking bench for the host-port configuration block
// assumes the package, constants header and controller model are compiled
`timescale 1ns/1ps
`include "host_port_consts.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module host_port_cfg_tb_top;
  import host_port_pkg::*;
  logic        clk, rst, irq_in, ods, adc_run, push_valid;
  logic [15:0] push_data;
  logic        push_ready_q, sda_out_q, sda_oe_n_q, slew_q, hs_q, adc_q;
  irq_pin_t    pin_q;
  logic        scl, sda_h, lo_wr, hi_rd, a;
  wire         sda_w = sda_h & (sda_oe_n_q | sda_out_q);
  int          fails, checked;
  logic [15:0] rq[$];
  logic [7:0]  ofs[5] = '{8'h1B, 8'h1C, 8'h1D, 8'h1F, 8'h00};
  logic [15:0] rv[5] = '{`RST_ADC_POST, `RST_PIN_PAD, `RST_PIN_POL, `RST_QUEUE_TH, 16'h0000};

  host_port_cfg #(.DEV_ADDR(7'h2A), .QAW(4)) i_dut (
    .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda_w), .irq_pin_in(irq_in),
    .open_drain_select(ods), .adc_run(adc_run), .push_valid(push_valid),
    .push_data(push_data), .push_ready_q(push_ready_q), .sda_out_q(sda_out_q),
    .sda_oe_n_q(sda_oe_n_q), .slew_limit_en_q(slew_q), .hs_mode_q(hs_q),
    .adc_sample_q(adc_q), .irq_pin_q(pin_q));

  host_ctrl_model m (.clk(clk), .sda_w(sda_w), .hs(hs_q), .scl(scl), .sda_h(sda_h));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ----------------------------------------
  // bus, queue push, pin check, ADC and verdict tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] p, input logic [15:0] v);
    m.start();
    m.wbyte(8'h54, a);
    `CHK("addr ack", 1'b1, a)
    m.wbyte(p, a);
    m.wbyte(lo_wr ? v[7:0] : v[15:8], a);
    m.wbyte(lo_wr ? v[15:8] : v[7:0], a);
    `CHK("data ack", 1'b1, a)
    m.stop();
    if (p == 8'h1E)
    begin
      lo_wr = v[10];
      hi_rd = v[7];
    end
  endtask : wr

  task automatic rd(input logic [7:0] p, input int n);
    logic [7:0] b1, b2;
    rq = {};
    m.start();
    m.wbyte(8'h54, a);
    m.wbyte(p, a);
    m.start();
    m.wbyte(8'h55, a);
    `CHK("read ack", 1'b1, a)
    for (int i = 0; i < n; i++)
    begin
      m.rbyte(b1, 1'b1);
      m.rbyte(b2, i < n - 1);
      rq.push_back(hi_rd ? {b1, b2} : {b2, b1});
    end
    m.stop();
  endtask : rd

  task automatic rchk(input logic [7:0] p, input logic [15:0] e);
    rd(p, 1);
    `CHK("reg", e, rq[0])
  endtask : rchk

  task automatic push(input logic [15:0] v);
    push_valid <= 1'b1;
    push_data <= v;
    @(posedge clk);
    push_valid <= 1'b0;
    @(posedge clk);
  endtask : push

  task automatic pchk(input logic [3:0] e);
    repeat (6) @(posedge clk);
    `CHK("pin", e, pin_q)
  endtask : pchk

  task automatic adc(input int e);
    int c;
    c = 0;
    adc_run <= 1'b1;
    repeat (4) @(posedge clk);
    repeat (20)
    begin
      @(posedge clk);
      #1;
      if (adc_q === 1'b1)
        c++;
    end
    `CHK("adc strobes", e, c)
    adc_run <= 1'b0;
  endtask : adc

  task automatic give_verdict();
    $display("fails=%0d checked=%0d", fails, checked);
    if (fails == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    {rst, irq_in, ods, adc_run, push_valid, push_data} = {1'b1, 20'h0};
    {fails, checked, lo_wr, hi_rd} = '0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("slew", 1'b1, slew_q)
    `CHK("pin", 4'b0100, pin_q)
    `CHK("hs", 1'b0, hs_q)
    `CHK("ready", 1'b1, push_ready_q)
    rchk(8'h1E, `RST_SERIAL_CTRL);
    wr(8'h1E, 16'h1480);
    `CHK("hs", 1'b1, hs_q)
    foreach (ofs[i])
      rchk(ofs[i], rv[i]);
    wr(8'h1F, 16'h0300);
    rchk(8'h1F, 16'h0300);
    wr(8'h30, 16'hFFFF);
    rchk(8'h30, 16'h0000);
    adc(20);
    wr(8'h1B, 16'h0020);
    adc(10);
    wr(8'h1E, 16'h1490);
    rchk(8'h00, 16'h0004);
    wr(8'h1E, 16'h1482);
    wr(8'h00, 16'h001F);
    rchk(8'h00, 16'h0001);
    wr(8'h1E, 16'h1484);
    wr(8'h00, 16'h001F);
    rchk(8'h00, 16'h0002);
    wr(8'h1E, 16'h14C0);
    wr(8'h00, 16'h001F);
    rd(8'h00, 1);
    rd(8'h00, 1);
    `CHK("txreq", 16'h0008, rq[0] & 16'h0008)
    wr(8'h1E, 16'h1488);
    m.start();
    m.wbyte(8'h54, a);
    `CHK("nack", 1'b0, a)
    m.stop();
    rchk(8'h1E, 16'h1480);
    wr(8'h00, 16'h001F);
    irq_in <= 1'b1;
    wr(8'h1C, 16'h2086);
    push(16'hA1B2);
    push(16'hC3D4);
    rchk(8'h00, 16'h0000);
    push(16'hE5F6);
    rchk(8'h00, 16'h0010);
    pchk(4'b1011);
    `CHK("slew", 1'b0, slew_q)
    wr(8'h1D, 16'h0020);
    pchk(4'b0001);
    wr(8'h1D, 16'h0000);
    wr(8'h1C, 16'hA086);
    pchk(4'b1101);
    wr(8'h1C, 16'h2086);
    ods <= 1'b1;
    pchk(4'b1101);
    ods <= 1'b0;
    wr(8'h1C, 16'h2080);
    pchk(4'b1100);
    wr(8'h1C, 16'h2086);
    rd(8'h60, 2);
    `CHK("queue word", 16'hA1B2, rq[0])
    `CHK("queue word", 16'hC3D4, rq[1])
    wr(8'h00, 16'h0010);
    pchk(4'b0001);
    give_verdict();
  end

  initial
  begin
    repeat (90000) @(posedge clk);
    fails++;
    give_verdict();
  end
endmodule : host_port_cfg_tb_top

// file: host_port_consts.svh
// constants for the host-port configuration block: offsets, fields, resets, timing
// assumes inclusion by bare name from the package and the design modules
// Functional notes
// - spacing bit set puts one idle cycle between ADC samples.
// - pin output enable clear means the interrupt pin is not driven.
// - pull-up disable bit keeps the pull-up driver off regardless.
// - polarity bit 0 gives active high, 1 gives active low.
// - input-enable bit lets the interrupt pin level be sensed inside.
// - slope bit, default set, enables slew limiting on both serial pads.
// - control bit 1 raises interrupt on start plus own address.
// - control bit 2 raises interrupt on start, address, repeated start.
// - control bit 3 answers the next communication with NACK.
// - control bit 4 raises interrupt on any detected stop.
// - control bit 6 raises interrupt during reads while queue not full.
// - control bit 7 sends upper byte of queue words first.
// - control bit 10 takes lower write byte first; host must match.
// - bit 12 selects fast or high-speed mode; host must match.
// - threshold bits 11:8 set minimum queued words for queue interrupt.
`ifndef HOST_PORT_CONSTS_SVH
`define HOST_PORT_CONSTS_SVH
`define OFS_IRQ_STATUS    8'h00
`define OFS_QUEUE_DATA    8'h60
`define OFS_ADC_POST      8'h1B
`define OFS_PIN_PAD       8'h1C
`define OFS_PIN_POL       8'h1D
`define OFS_SERIAL_CTRL   8'h1E
`define OFS_QUEUE_TH      8'h1F
`define RST_ADC_POST      16'h0000
`define RST_PIN_PAD       16'h2090
`define RST_PIN_POL       16'h0000
`define RST_SERIAL_CTRL   16'h0001
`define RST_QUEUE_TH      16'h0000
`define BIT_ADC_SPACING   5
`define BIT_PIN_IE        1
`define BIT_PIN_OE        2
`define BIT_SLOPE_EN      4
`define BIT_PULLUP_DIS    15
`define BIT_PIN_POL       5
`define BIT_IRQ_ADDR      1
`define BIT_IRQ_RSTART    2
`define BIT_NACK          3
`define BIT_IRQ_STOP      4
`define BIT_IRQ_TXREQ     6
`define BIT_HI_FIRST      7
`define BIT_LO_WR_FIRST   10
`define BIT_SPEED_HS      12
`define TH_MSB            11
`define TH_LSB            8
`define ST_ADDR_HIT       0
`define ST_RSTART         1
`define ST_STOP           2
`define ST_TXREQ          3
`define ST_QUEUE          4
`define FAST_KHZ          400
`define HS_KHZ            3400
`endif

// file: host_port_pkg.sv
// types shared by the host-port configuration block
// assumes the constants header sits in the same folder
package host_port_pkg;
  `include "host_port_consts.svh"

  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_REG, S_WR, S_ACK, S_RD, S_MACK
  } port_state_t;

  typedef struct packed {
    logic level;
    logic oe_n;
    logic pullup_on;
    logic sensed;
  } irq_pin_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  addr;
    logic [15:0] data;
  } reg_write_t;
endpackage : host_port_pkg

// file: queue_mem.sv
// word store for the host-port data queue, registered read data
// assumes one clock, one write port and one read address per cycle
`timescale 1ns/1ps
module queue_mem #(
  parameter int WIDTH = 16,
  parameter int AW    = 4
) (
  input  wire logic             clk,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata_q
);
  logic [WIDTH-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata_q <= mem[raddr];
  end
endmodule : queue_mem
